//--- rtl/conv_port_pkg.sv
// package: constants for the converter serial port pin logic
package conv_port_pkg;

  // ****************************************
  // clock modes
  // ****************************************
  localparam logic [1:0] CLK_MODE_RISE_OUT = 2'h3; // only mode that shifts out on rising edge

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int         FRAME_BITS     = 8;
  localparam int         DAC_CH         = 4;
  localparam int         DAC_BITS       = 10;
  localparam logic [7:0] SHIFT_RESET    = 8'h00;
  localparam logic [9:0] DAC_RESET      = 10'h000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS      = 20;
  localparam int LOAD_PULSE_MIN_NS  = 20;
  localparam int LOAD_PULSE_CYC     =
    (LOAD_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- rtl/converter_serial_port_pins.sv
// module: pin-level serial host port with end-of-conversion and dac load
// ****************************************
// ****************************************
`timescale 1ns/1ps
module converter_serial_port_pins #(
  parameter int FRAME_BITS = conv_port_pkg::FRAME_BITS,
  parameter int DAC_CH     = conv_port_pkg::DAC_CH,
  parameter int DAC_BITS   = conv_port_pkg::DAC_BITS
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // serial pins
  input  wire logic                       cs_n,
  input  wire logic                       sclk,
  input  wire logic                       din,
  output logic                            dout_o,
  output logic                            dout_oe,
  // end of conversion and dac load pins
  output logic                            eoc_n,
  input  wire logic                       dac_load_n,
  // core side
  input  wire logic [1:0]                 clk_mode,
  input  wire logic                       conv_done,
  input  wire logic [FRAME_BITS-1:0]      tx_word,
  output logic [FRAME_BITS-1:0]           rx_word,
  output logic                            rx_valid,
  input  wire logic                       dac_wr,
  input  wire logic [$clog2(DAC_CH)-1:0]  dac_wr_ch,
  input  wire logic [DAC_BITS-1:0]        dac_wr_data,
  output logic [DAC_CH*DAC_BITS-1:0]      dac_analog_outputs
);

  localparam int CW = $clog2(FRAME_BITS + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       sclk_prev;

  // first stage read only by the second stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1     <= 4'hf;
      sync2     <= 4'hf;
      sclk_prev <= 1'b1; // matches parked-high sclk, so no false rise after reset
    end
    else
    begin
      sync1     <= {cs_n, sclk, din, dac_load_n};
      sync2     <= sync1;
      sclk_prev <= sync2[2];
    end
  end

  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic load_n_s;
  logic sclk_fall;
  logic sclk_rise;
  logic out_edge;
  assign cs_n_s    = sync2[3];
  assign sclk_s    = sync2[2];
  assign din_s     = sync2[1];
  assign load_n_s  = sync2[0];
  assign sclk_fall = sclk_prev & ~sclk_s;
  assign sclk_rise = ~sclk_prev & sclk_s;
  // mode 11 moves output shifting to the rising edge
  assign out_edge  = (clk_mode == conv_port_pkg::CLK_MODE_RISE_OUT) ? sclk_rise
                                                                     : sclk_fall;

  // ****************************************
  // shift engine
  // ****************************************
  logic [FRAME_BITS-1:0] rx_sh;
  logic [FRAME_BITS-1:0] tx_sh;
  logic [CW-1:0]         bit_cnt;
  logic                  dout_q;
  logic                  active;
  logic [FRAME_BITS-1:0] next_rx_sh;
  logic [FRAME_BITS-1:0] next_tx_sh;
  logic [CW-1:0]         next_bit_cnt;
  logic                  next_dout_q;
  logic                  next_active;
  logic [FRAME_BITS-1:0] next_rx_word;
  logic                  next_rx_valid;

  // next-state of the serial shifter
  always_comb
  begin
    next_rx_sh    = rx_sh;
    next_tx_sh    = tx_sh;
    next_bit_cnt  = bit_cnt;
    next_dout_q   = dout_q;
    next_active   = ~cs_n_s;
    next_rx_word  = rx_word;
    next_rx_valid = 1'b0;
    if (cs_n_s)
    begin
      // idle: preload so first bit is ready at select
      next_tx_sh   = tx_word;
      next_dout_q  = tx_word[FRAME_BITS-1];
      next_bit_cnt = '0;
    end
    else
    begin
      if (sclk_fall)
      begin
        next_rx_sh = {rx_sh[FRAME_BITS-2:0], din_s};
        if (bit_cnt == CW'(FRAME_BITS - 1))
        begin
          next_bit_cnt  = '0;
          next_rx_word  = {rx_sh[FRAME_BITS-2:0], din_s};
          next_rx_valid = 1'b1;
        end
        else
          next_bit_cnt = bit_cnt + CW'(1);
      end
      if (out_edge)
      begin
        next_tx_sh  = {tx_sh[FRAME_BITS-2:0], 1'b0};
        next_dout_q = tx_sh[FRAME_BITS-2];
      end
    end
  end

  // shifter registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sh    <= '0;
      tx_sh    <= '0;
      bit_cnt  <= '0;
      dout_q   <= 1'b0;
      active   <= 1'b0;
      rx_word  <= '0;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_sh    <= next_rx_sh;
      tx_sh    <= next_tx_sh;
      bit_cnt  <= next_bit_cnt;
      dout_q   <= next_dout_q;
      active   <= next_active;
      rx_word  <= next_rx_word;
      rx_valid <= next_rx_valid;
    end
  end

  // released while deselected so other devices may share the line
  assign dout_o  = dout_q;
  assign dout_oe = active;

  // ****************************************
  // end of conversion
  // ****************************************
  logic next_eoc_n;

  // low on completion, released when host selects to read
  always_comb
  begin
    next_eoc_n = eoc_n;
    if (conv_done)
      next_eoc_n = 1'b0;
    else if (!cs_n_s)
      next_eoc_n = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      eoc_n <= 1'b1;
    else
      eoc_n <= next_eoc_n;
  end

  // ****************************************
  // dac input and output registers
  // ****************************************
  logic [DAC_CH*DAC_BITS-1:0] dac_in;
  logic [DAC_CH*DAC_BITS-1:0] next_dac_in;
  logic [DAC_CH*DAC_BITS-1:0] next_dac_out;

  // load is sampled through the synchroniser, so the pin may move at any time; it takes effect on clk
  always_comb
  begin
    next_dac_in = dac_in;
    if (dac_wr)
      next_dac_in[dac_wr_ch*DAC_BITS +: DAC_BITS] = dac_wr_data;
    // transparent while load held low: new writes pass at once
    next_dac_out = load_n_s ? dac_analog_outputs : next_dac_in;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dac_in             <= {DAC_CH{conv_port_pkg::DAC_RESET}};
      dac_analog_outputs <= {DAC_CH{conv_port_pkg::DAC_RESET}};
    end
    else
    begin
      dac_in             <= next_dac_in;
      dac_analog_outputs <= next_dac_out;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_dout_released;
    @(posedge clk) disable iff (!rst_b) cs_n_s |=> !dout_oe;
  endproperty
  a_dout_released: assert property (p_dout_released) else $error("dout driven while deselected");

  property p_capture_fall;
    @(posedge clk) disable iff (!rst_b)
      (!cs_n_s && sclk_fall) |=> rx_sh[0] == $past(din_s);
  endproperty
  a_capture_fall: assert property (p_capture_fall) else $error("input bit not captured");

  property p_shift_fall;
    @(posedge clk) disable iff (!rst_b)
      (!cs_n_s && clk_mode != 2'h3 && !sclk_fall) |=> $stable(dout_q);
  endproperty
  a_shift_fall: assert property (p_shift_fall) else $error("output moved off falling edge");

  property p_shift_rise;
    @(posedge clk) disable iff (!rst_b)
      (!cs_n_s && clk_mode == 2'h3 && !sclk_rise) |=> $stable(dout_q);
  endproperty
  a_shift_rise: assert property (p_shift_rise) else $error("output moved off rising edge");

  property p_eoc_low;
    @(posedge clk) disable iff (!rst_b) conv_done |=> !eoc_n;
  endproperty
  a_eoc_low: assert property (p_eoc_low) else $error("eoc not low after completion");

  property p_dac_hold;
    @(posedge clk) disable iff (!rst_b) load_n_s |=> $stable(dac_analog_outputs);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac output changed without load");

  property p_dac_transparent;
    @(posedge clk) disable iff (!rst_b)
      !load_n_s |=> dac_analog_outputs == dac_in;
  endproperty
  a_dac_transparent: assert property (p_dac_transparent) else $error("dac not transparent");

  sequence s_word_done;
    !cs_n_s && sclk_fall && bit_cnt == CW'(FRAME_BITS - 1);
  endsequence
  property p_word_valid;
    @(posedge clk) disable iff (!rst_b) s_word_done |=> rx_valid ##1 !rx_valid;
  endproperty
  a_word_valid: assert property (p_word_valid) else $error("rx word pulse wrong");

endmodule

//--- test/host_model.sv
// host-side serial master model for the converter port pins
`timescale 1ns/1ps
module host_model (
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout,
  // conversion status
  input  wire logic eoc_n
);
  // idle state: deselected, clock parked high
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // released data line toggles so stale data never looks valid
  always #40 if (cs_n) din = ~din;

  // one 8-bit frame; sel low clocks with the port deselected
  task automatic xfer(input logic sel, input logic [7:0] tx, output logic [7:0] rx,
                      output logic [7:0] rxl);
    int n;
    n = 0;
    while (sel && eoc_n !== 1'b0 && n < 1000)
    begin
      #20;
      n++;
    end
    cs_n = ~sel;
    #100;
    for (int i = 7; i >= 0; i--)
    begin
      if (sel) din = tx[i];
      #80;
      // sample before the fall: both out-edge modes are settled here
      rx[i] = dout;
      sclk = 1'b0;
      #80;
      // sample before the rise: falling-edge modes have moved on, mode 11 has not
      rxl[i] = dout;
      sclk = 1'b1;
    end
    #100;
    cs_n = 1'b1;
    #100;
  endtask
endmodule

//--- test/tb.sv
// self-checking bench for the converter serial port pins
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst_b, cs_n, sclk, din, dout_o, dout_oe, eoc_n;
  logic        dac_load_n, conv_done, rx_valid, dac_wr;
  logic [1:0]  clk_mode, dac_wr_ch;
  logic [7:0]  tx_word, rx_word, hrx, hrxl, dbyte;
  logic [9:0]  dac_wr_data;
  logic [39:0] dac_analog_outputs;
  wire         dout = dout_oe ? dout_o : 1'bz;
  int          mismatches, tests_run, cycles, dac_m[4];
  logic [7:0]  rxq[$];

  converter_serial_port_pins dut_u (.clk(clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .eoc_n(eoc_n), .dac_load_n(dac_load_n),
    .clk_mode(clk_mode), .conv_done(conv_done), .tx_word(tx_word), .rx_word(rx_word),
    .rx_valid(rx_valid), .dac_wr(dac_wr), .dac_wr_ch(dac_wr_ch), .dac_wr_data(dac_wr_data),
    .dac_analog_outputs(dac_analog_outputs));
  host_model host_u (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .eoc_n(eoc_n));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t value %h exp %h", $time, got, exp);
    end
  endtask

  // expected dac output image from the integer model
  function automatic logic [39:0] dac_img();
    logic [39:0] v;
    v = '0;
    for (int i = 0; i < 4; i++) v[i*10 +: 10] = 10'(dac_m[i]);
    return v;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // clock, received-word collector and hang guard
  always #10 clk = ~clk;
  always @(negedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_word);
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // main sequence: frames in every clock mode, then dac loading
  initial
  begin
    rst_b = 1'b0;
    dac_load_n = 1'b1;
    clk_mode = 2'h0;
    conv_done = 1'b0;
    tx_word = 8'h00;
    dac_wr = 1'b0;
    dac_wr_ch = 2'h0;
    dac_wr_data = 10'h000;
    void'($urandom(75));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(dout_oe, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      tx_word = 8'($urandom);
      dbyte = 8'($urandom);
      clk_mode = 2'(m);
      chk_bit(eoc_n, 1'b1);
      conv_done = 1'b1;
      @(negedge clk) conv_done = 1'b0;
      chk_bit(eoc_n, 1'b0);
      host_u.xfer(1'b1, dbyte, hrx, hrxl);
      repeat (8) @(negedge clk);
      chk_val(40'(hrx), 40'(tx_word));
      chk_val(40'(hrxl[7:1]), 40'((m == 3) ? tx_word[7:1] : tx_word[6:0]));
      chk_val(40'(rxq.size()), 40'h1);
      chk_val(40'(rxq.pop_front()), 40'(dbyte));
      chk_bit(dout_oe, 1'b0);
    end
    // clocking while deselected must not deliver a word
    host_u.xfer(1'b0, 8'h00, hrx, hrxl);
    repeat (8) @(negedge clk);
    chk_val(40'(rxq.size()), 40'h0);
    // first two writes checked held back, load goes low after the third write and stays low
    for (int c = 0; c < 4; c++)
    begin
      dac_wr_ch = 2'(c);
      dac_wr_data = 10'($urandom);
      dac_m[c] = int'(dac_wr_data);
      dac_wr = 1'b1;
      @(negedge clk) dac_wr = 1'b0;
      if (c == 2) dac_load_n = 1'b0;
      repeat (5) @(negedge clk);
      chk_val(dac_analog_outputs, (c < 2) ? 40'h0 : dac_img());
    end
    stop_test();
  end
endmodule
